/* File: hdl/pcc_top.sv */
// shared pwm cycle length configuration register of the counter array
// How it works
// - reload select steers compare accesses to reload
// - reload values used only in 9-11 bit pwm
// - overflow flag raises interrupt when enabled
// - flag set on selected 8-11 bit overflow
// - hardware or software sets; only software clears
// - bits four to two read zero
// - select 00/01/11 gives 8/9/11 bits
// - length shared by all non-wide pwm channels
// - wide enable forces 16-bit pwm cycle
`timescale 1ns/1ns
module pcc_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // special function register bus
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    // counter array
    input  wire logic [15:0] main_counter,
    input  wire logic [5:0]  pwm_enable,
    input  wire logic [5:0]  wide_pwm_enable,
    // derived controls
    output logic             reload_register_select,
    output logic             cycle_overflow_irq,
    output logic [1:0]       cycle_length_select,
    output logic [5:0]       reload_active,
    output logic [5:0]       wide_cycle_active,
    output logic [5:0]       short_cycle_active
);
    // configuration state
    logic       reload_sel_ff;
    logic       nxt_reload_sel;
    logic       ovf_ie_ff;
    logic       nxt_ovf_ie;
    logic       ovf_flag_ff;
    logic       nxt_ovf_flag;
    logic [1:0] len_sel_ff;
    logic [1:0] nxt_len_sel;

    // bus side
    logic       cfg_wr;
    logic       cfg_rd;
    logic [7:0] cfg_view;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // interrupt request
    logic       irq_ff;
    logic       nxt_irq;

    // overflow event from the detector
    logic       ovf_pulse;

    // per-channel modes
    logic [5:0] wide_act_ff;
    logic [5:0] short_act_ff;
    logic [5:0] reload_act_ff;

    // the same address match serves reads and writes
    function automatic logic cfg_hit(input logic [7:0] addr);
        cfg_hit = (addr == pcc_pkg::PWM_CFG_ADDR);
    endfunction

    // only lengths above eight bits take their top from the reload registers
    function automatic logic uses_reload(input logic [1:0] len);
        uses_reload = (len != pcc_pkg::LEN_8);
    endfunction

    always_comb begin
        cfg_wr = sfr_wr && cfg_hit(sfr_addr);
        cfg_rd = sfr_rd && cfg_hit(sfr_addr);
    end

    pcc_ovf_detect i_pcc_ovf_detect (
        .core_clk            (core_clk),
        .resetn              (resetn),
        .main_counter        (main_counter),
        .cycle_length_select (len_sel_ff),
        .ovf_pulse           (ovf_pulse)
    );

    // reload register select
    always_comb begin
        nxt_reload_sel = reload_sel_ff;
        if (cfg_wr) begin
            nxt_reload_sel = sfr_wdata[pcc_pkg::RELOAD_SEL_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reload_sel_ff <= pcc_pkg::PWM_CFG_RESET[pcc_pkg::RELOAD_SEL_BIT];
        end else begin
            reload_sel_ff <= nxt_reload_sel;
        end
    end

    // overflow interrupt enable
    always_comb begin
        nxt_ovf_ie = ovf_ie_ff;
        if (cfg_wr) begin
            nxt_ovf_ie = sfr_wdata[pcc_pkg::OVF_IE_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ovf_ie_ff <= pcc_pkg::PWM_CFG_RESET[pcc_pkg::OVF_IE_BIT];
        end else begin
            ovf_ie_ff <= nxt_ovf_ie;
        end
    end

    // cycle length select
    always_comb begin
        nxt_len_sel = len_sel_ff;
        if (cfg_wr) begin
            nxt_len_sel = sfr_wdata[pcc_pkg::LEN_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            len_sel_ff <= pcc_pkg::PWM_CFG_RESET[pcc_pkg::LEN_LSB +: 2];
        end else begin
            len_sel_ff <= nxt_len_sel;
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_comb begin
        nxt_ovf_flag = ovf_flag_ff;
        if (cfg_wr) begin
            nxt_ovf_flag = sfr_wdata[pcc_pkg::OVF_FLAG_BIT];
        end
        if (ovf_pulse) begin
            nxt_ovf_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ovf_flag_ff <= pcc_pkg::PWM_CFG_RESET[pcc_pkg::OVF_FLAG_BIT];
        end else begin
            ovf_flag_ff <= nxt_ovf_flag;
        end
    end

    // built from next-state values so the request never lags the flag by a cycle
    always_comb begin
        nxt_irq = nxt_ovf_flag && nxt_ovf_ie;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_ff <= pcc_pkg::IRQ_RESET;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    always_comb begin
        cfg_view = pcc_pkg::RDATA_IDLE;
        cfg_view[pcc_pkg::RELOAD_SEL_BIT] = reload_sel_ff;
        cfg_view[pcc_pkg::OVF_IE_BIT]     = ovf_ie_ff;
        cfg_view[pcc_pkg::OVF_FLAG_BIT]   = ovf_flag_ff;
        cfg_view[pcc_pkg::LEN_LSB +: 2]   = len_sel_ff;
    end

    // other addresses belong to neighbouring blocks, so this block returns zero there
    always_comb begin
        nxt_rdata = pcc_pkg::RDATA_IDLE;
        if (cfg_rd) begin
            nxt_rdata = cfg_view;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rdata_ff <= pcc_pkg::RDATA_IDLE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // per-channel mode decode
    genvar ch;
    generate
        for (ch = 0; ch < pcc_pkg::NUM_CH; ch++) begin : g_ch
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    wide_act_ff[ch]   <= pcc_pkg::CH_RESET[ch];
                    short_act_ff[ch]  <= pcc_pkg::CH_RESET[ch];
                    reload_act_ff[ch] <= pcc_pkg::CH_RESET[ch];
                end else begin
                    wide_act_ff[ch]   <= pwm_enable[ch] && wide_pwm_enable[ch];
                    short_act_ff[ch]  <= pwm_enable[ch] && !wide_pwm_enable[ch];
                    reload_act_ff[ch] <= pwm_enable[ch] && !wide_pwm_enable[ch]
                                         && uses_reload(len_sel_ff);
                end
            end
        end
    endgenerate

    // outputs straight from their flip-flops
    assign reload_register_select = reload_sel_ff;
    assign cycle_overflow_irq     = irq_ff;
    assign cycle_length_select    = len_sel_ff;
    assign sfr_rdata              = rdata_ff;
    assign wide_cycle_active      = wide_act_ff;
    assign short_cycle_active     = short_act_ff;
    assign reload_active          = reload_act_ff;
endmodule

/* File: hdl/pcc_pkg.sv */
// constants for the pwm cycle length configuration block
package pcc_pkg;
    localparam logic [7:0] PWM_CFG_ADDR  = 8'hDF;
    localparam logic [7:0] PWM_CFG_RESET = 8'h00;
    localparam int         RELOAD_SEL_BIT = 7;
    localparam logic [5:0] CH_RESET       = 6'h00;
    localparam logic [7:0] RDATA_IDLE     = 8'h00;
    localparam logic       IRQ_RESET      = 1'b0;
    localparam logic [11:0] PREV_RESET    = 12'h000;
    localparam int         OVF_IE_BIT    = 6;
    localparam int         OVF_FLAG_BIT  = 5;
    localparam int         LEN_LSB       = 0;
    localparam int         NUM_CH        = 6;
    localparam logic [1:0] LEN_8         = 2'h0;
    localparam logic [1:0] LEN_9         = 2'h1;
    localparam logic [1:0] LEN_10        = 2'h2;
    localparam logic [1:0] LEN_11        = 2'h3;
    typedef enum logic [1:0] {
        PCC_MODE_OFF    = 2'h0,
        PCC_MODE_SHORT  = 2'h1,
        PCC_MODE_WIDE   = 2'h3
    } pcc_mode_t;
endpackage

/* File: hdl/pcc_ovf_detect.sv */
// detects overflow out of the selected cycle-length bit of the main counter
`timescale 1ns/1ns
module pcc_ovf_detect (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // counter and selection
    input  wire logic [15:0] main_counter,
    input  wire logic [1:0]  cycle_length_select,
    // result
    output logic             ovf_pulse
);
    logic [11:0] prev_ff;
    logic        sel_now;
    logic        sel_prev;

    // an overflow is the chosen carry bit's low part changing from any nonzero value to zero
    function automatic logic low_zero(input logic [11:0] v, input logic [1:0] len);
        unique case (len)
            pcc_pkg::LEN_8:  low_zero = (v[7:0] == 8'h00);
            pcc_pkg::LEN_9:  low_zero = (v[8:0] == 9'h000);
            pcc_pkg::LEN_10: low_zero = (v[9:0] == 10'h000);
            pcc_pkg::LEN_11: low_zero = (v[10:0] == 11'h000);
        endcase
    endfunction

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prev_ff <= pcc_pkg::PREV_RESET;
        end else begin
            prev_ff <= main_counter[11:0];
        end
    end

    always_comb begin
        sel_now  = low_zero(main_counter[11:0], cycle_length_select);
        sel_prev = low_zero(prev_ff, cycle_length_select);
        ovf_pulse = sel_now && !sel_prev && (main_counter[11:0] != prev_ff);
    end
endmodule

/* File: dv/pcc_props.sv */
// assertion checker for the pwm cycle length configuration block
`timescale 1ns/1ns
module pcc_props (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // register bus
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // counter array
    input wire logic [5:0] pwm_enable,
    input wire logic [5:0] wide_pwm_enable,
    // derived controls
    input wire logic [5:0] reload_active,
    input wire logic [5:0] wide_cycle_active,
    input wire logic [5:0] short_cycle_active,
    input wire logic       reload_register_select,
    input wire logic       cycle_overflow_irq,
    input wire logic [1:0] cycle_length_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic wr_cfg;
    assign wr_cfg = sfr_wr && sfr_addr == pcc_pkg::PWM_CFG_ADDR;
    property p_sel; wr_cfg |=> reload_register_select == $past(sfr_wdata[7]); endproperty
    a_sel: assert property (p_sel) else $error("bad select");
    property p_len; wr_cfg |=> cycle_length_select == $past(sfr_wdata[1:0]); endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_zero; sfr_rd && sfr_addr == 8'hDF |=> sfr_rdata[4:2] == 3'h0; endproperty
    a_zero: assert property (p_zero) else $error("unused bits set");
    property p_mask; wr_cfg && !sfr_wdata[6] |=> !cycle_overflow_irq; endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    property p_keep; cycle_overflow_irq && !sfr_wr |=> cycle_overflow_irq; endproperty
    a_keep: assert property (p_keep) else $error("flag lost");
    property p_wide; 1'b1 |=> wide_cycle_active == $past(pwm_enable & wide_pwm_enable); endproperty
    a_wide: assert property (p_wide) else $error("bad wide");
    property p_short; 1'b1 |=> short_cycle_active == $past(pwm_enable & ~wide_pwm_enable);
    endproperty
    a_short: assert property (p_short) else $error("bad short");
    // no write in the cause cycle, so old and new length agree
    property p_rel; !sfr_wr |=> reload_active == $past(pwm_enable & ~wide_pwm_enable
        & {6{cycle_length_select != 2'h0}}); endproperty
    a_rel: assert property (p_rel) else $error("bad reload");
    property p_other; sfr_rd && sfr_addr != 8'hDF |=> sfr_rdata == 8'h00; endproperty
    a_other: assert property (p_other) else $error("foreign read not zero");
endmodule
bind pcc_top pcc_props i_pcc_props (
    .core_clk(core_clk), .resetn(resetn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .pwm_enable(pwm_enable), .wide_pwm_enable(wide_pwm_enable),
    .reload_active(reload_active), .wide_cycle_active(wide_cycle_active),
    .short_cycle_active(short_cycle_active),
    .reload_register_select(reload_register_select),
    .cycle_overflow_irq(cycle_overflow_irq), .cycle_length_select(cycle_length_select)
);

/* File: dv/tb_pcc_top.sv */
// self-checking bench for the pwm cycle length configuration block
`timescale 1ns/1ns
module tb_pcc_top;
    localparam logic [7:0] CFG = pcc_pkg::PWM_CFG_ADDR;
    logic        core_clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [15:0] main_counter = 16'h0000;
    logic [5:0]  pwm_enable = 6'h00, wide_pwm_enable = 6'h00;
    logic [5:0]  reload_active, wide_cycle_active, short_cycle_active;
    logic        reload_register_select, cycle_overflow_irq;
    logic [1:0]  cycle_length_select;
    int          errors = 0, n_checks = 0, seed = 78, m = 0;
    pcc_top i_pcc_top (.*);
    always #5 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one register access; reads compared with the model
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= w;
        sfr_rd    <= ~w;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        @(negedge core_clk);
        if (w && a == CFG) m = d & 8'hE3;
        if (!w) chk(sfr_rdata, a == CFG ? m[7:0] : 8'h00);
    endtask
    // flag is sticky, so an extra cycle of detection latency is harmless
    task automatic cnt(input logic [15:0] a, input logic [15:0] b, input logic e);
        @(posedge core_clk);
        main_counter <= a;
        @(posedge core_clk);
        main_counter <= b;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({7'h00, cycle_overflow_irq}, {7'h00, e});
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        acc(CFG, 8'h00, 1'b0);
        for (int c = 0; c < 4; c++) begin
            acc(CFG, 8'h5C | c[7:0], 1'b1);
            chk({6'h00, cycle_length_select}, c[7:0]);
            cnt(16'h00FF, 16'h0100, c == 0);
            cnt((16'h0001 << (8 + c)) - 16'h0001, 16'h0001 << (8 + c), 1'b1);
            m = m | 8'h20;
            acc(CFG, 8'h00, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            acc(CFG, k[0] ? 8'h60 : 8'h20, 1'b1);
            chk({7'h00, cycle_overflow_irq}, k[7:0]);
        end
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            pwm_enable      <= 6'($random(seed));
            wide_pwm_enable <= 6'($random(seed));
            acc(CFG, 8'($random(seed)), 1'b1);
            acc(CFG, 8'h00, 1'b0);
            chk({7'h00, reload_register_select}, {7'h00, m[7]});
            chk({2'h0, wide_cycle_active}, {2'h0, pwm_enable & wide_pwm_enable});
            chk({2'h0, short_cycle_active}, {2'h0, pwm_enable & ~wide_pwm_enable});
            chk({2'h0, reload_active},
                {2'h0, pwm_enable & ~wide_pwm_enable & {6{m[1:0] != 2'h0}}});
            chk({7'h00, cycle_overflow_irq}, {7'h00, m[5] & m[6]});
        end
        acc(8'hDE, 8'hFF, 1'b1);
        acc(8'hDE, 8'h00, 1'b0);
        acc(CFG, 8'h00, 1'b0);
        results();
    end
endmodule
